// *** hpm_pkg.sv ***
// Package for the host pin function mux
package hpm_pkg;
  // Register byte offsets
  localparam logic [7:0] HPM_CFG_OFF = 8'h00;
  localparam logic [7:0] HPM_STAT_OFF = 8'h04;
  localparam logic [7:0] HPM_IEN_OFF = 8'h08;
  localparam logic [7:0] HPM_ICLR_OFF = 8'h0C;
  localparam logic [7:0] HPM_FIFO_OFF = 8'h10;
  // Config field positions
  localparam int HPM_TXREG_EN_BIT = 0;
  localparam int HPM_FILT_DIG_BIT = 4;
  localparam int HPM_FIFO_EN_BIT = 6;
  localparam int HPM_PIN16_VD_BIT = 8;
  localparam int HPM_HOST_CLOCK_OUTPUT_EN_BIT = 9;
  localparam int HPM_SLEEP_BIT = 10;
  localparam int HPM_TXACC_BIT = 11;
  localparam int HPM_LIMIT_LSB = 12;
  localparam int HPM_LIMIT_W = 4;
  localparam int HPM_CLKDIV_LSB = 16;
  localparam int HPM_CLKDIV_W = 8;
  localparam logic [31:0] HPM_CFG_RST = 32'h0000_F000;
  // Event bits
  localparam int HPM_NEV = 8;
  localparam int HPM_EV_TXRDY = 0;
  localparam int HPM_EV_FFILL = 1;
  localparam int HPM_EV_POR = 2;
  localparam int HPM_EV_OVUN = 3;
  localparam int HPM_EV_WKUP = 4;
  localparam int HPM_EV_EXT = 5;
  localparam int HPM_EV_LBAT = 6;
  localparam int HPM_EV_DVALID = 7;
  localparam logic [1:0] HPM_RESP_OK = 2'h0;
  localparam logic [1:0] HPM_RESP_SLVERR = 2'h2;
  // Reset pin drive time
  localparam int HPM_CLK_MHZ = 200;
  localparam int HPM_RST_DRIVE_MS = 100;
  localparam int HPM_RST_DRIVE_CYC = HPM_RST_DRIVE_MS * 1000 * HPM_CLK_MHZ;
  typedef enum logic [1:0] {HPM_IDLE = 2'h0, HPM_WRESP = 2'h1, HPM_RRESP = 2'h3} hpm_bus_t;
endpackage

// *** hpm_pin_mux.sv ***
// Host pin function mux with AXI4-Lite control registers
// Contract
// - With transmit register disabled, host data on data pin becomes modulation data.
// - Without FIFO and with transmit register disabled, data pin outputs received data with recovered clock.
// - FIFO select during read presents first stored bit on next serial clock.
// - Data pin pulled high internally during transmit register access.
// - Digital filter on and FIFO off: clock pin outputs recovered clock.
// - Digital filter on and FIFO on: clock pin is FIFO-full interrupt at programmed limit.
// - Analog filter: clock pin carries raw baseband data.
// - Reset pin driven 100 ms after power-up, then active-low input.
// - Low on external interrupt input raises interrupt request output.
// - Interrupt source reported in first four status bits; code uses eight status bits (external interrupt is bit 5).
// - Low external interrupt input also wakes the device.
// - Valid-data mode: pin shows recognizer's valid-data flag.
// - Optional host clock output.
// - Interrupt request output active low, set by listed events.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module hpm_pin_mux
  import hpm_pkg::*;
#(
  parameter int RST_DRIVE_CYC = HPM_RST_DRIVE_CYC,
  parameter int FIFO_DEPTH = 16
)(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_data,
  input wire logic rx_recclk,
  input wire logic rx_baseband,
  input wire logic sync_valid,
  input wire logic [HPM_NEV-1:0] core_events,
  input wire logic serial_clock,
  input wire logic serial_chip_select_n,
  input wire logic data_fifo_select_pin_in,
  output logic data_fifo_select_pin_out,
  output logic data_fifo_select_pin_oe,
  output logic tx_mod_data,
  output logic recclk_fifoint_filtcap_pin_out,
  output logic recclk_fifoint_filtcap_pin_oe,
  input wire logic reset_bidir_pin_in,
  output logic reset_bidir_pin_out,
  output logic reset_bidir_pin_oe,
  output logic device_reset,
  input wire logic ext_irq_valid_data_pin_in,
  output logic ext_irq_valid_data_pin_out,
  output logic ext_irq_valid_data_pin_oe,
  output logic wake_event,
  output logic interrupt_request_output_n,
  output logic host_clock_output
);
  localparam int CW = $clog2(RST_DRIVE_CYC + 1);
  localparam int FW = $clog2(FIFO_DEPTH);

  typedef struct packed {
    hpm_bus_t bus;
    logic awok;
    logic wok;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arready;
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic [31:0] cfg;
    logic [HPM_NEV-1:0] stat;
    logic [HPM_NEV-1:0] ien;
    logic [FIFO_DEPTH-1:0] fifo;
    logic [FW:0] fcount;
    logic [FW-1:0] rptr;
    logic [2:0] s_sck;
    logic [1:0] s_cs;
    logic [1:0] s_dat;
    logic [1:0] s_rst;
    logic [1:0] s_ext;
    logic [2:0] s_rclk;
    logic [1:0] s_rxd;
    logic [1:0] s_bb;
    logic [1:0] s_vd;
    logic ext_prev;
    logic [CW-1:0] rcnt;
    logic rdrive;
    logic [HPM_CLKDIV_W-1:0] ccnt;
    logic cout;
    logic d_out;
    logic d_oe;
    logic txd;
    logic p7;
    logic p7_oe;
    logic rst_o;
    logic rst_oe;
    logic devrst;
    logic p16;
    logic p16_oe;
    logic wake;
    logic irq_n;
  } hpm_state_t;

  hpm_state_t st_reg;
  hpm_state_t st_next;

  always_comb
  begin
    logic [31:0] rd;
    logic txen;
    logic fifoen;
    logic digf;
    logic vdmode;
    logic sck_rise;
    logic rclk_rise;
    logic fsel;
    logic fifo_full;
    logic ext_low;
    logic [HPM_NEV-1:0] ev;
    logic [HPM_NEV-1:0] clr;
    logic [FW:0] limit;
    rd = 32'h0000_0000;
    st_next = st_reg;
    clr = '0;
    txen = st_reg.cfg[HPM_TXREG_EN_BIT];
    fifoen = st_reg.cfg[HPM_FIFO_EN_BIT];
    digf = st_reg.cfg[HPM_FILT_DIG_BIT];
    vdmode = st_reg.cfg[HPM_PIN16_VD_BIT];
    limit = (FW+1)'(st_reg.cfg[HPM_LIMIT_LSB +: HPM_LIMIT_W]);
    // Pin synchronisers
    st_next.s_sck = {st_reg.s_sck[1:0], serial_clock};
    st_next.s_cs = {st_reg.s_cs[0], serial_chip_select_n};
    st_next.s_dat = {st_reg.s_dat[0], data_fifo_select_pin_in};
    st_next.s_rst = {st_reg.s_rst[0], reset_bidir_pin_in};
    st_next.s_ext = {st_reg.s_ext[0], ext_irq_valid_data_pin_in};
    st_next.s_rclk = {st_reg.s_rclk[1:0], rx_recclk};
    st_next.s_rxd = {st_reg.s_rxd[0], rx_data};
    st_next.s_bb = {st_reg.s_bb[0], rx_baseband};
    st_next.s_vd = {st_reg.s_vd[0], sync_valid};
    sck_rise = st_reg.s_sck[1] & ~st_reg.s_sck[2];
    rclk_rise = st_reg.s_rclk[1] & ~st_reg.s_rclk[2];
    // Data pin
    st_next.txd = txen ? 1'b1 : st_reg.s_dat[1];
    fsel = fifoen & ~st_reg.s_cs[1] & ~st_reg.s_dat[1];
    st_next.d_oe = 1'b0;
    st_next.d_out = 1'b1;
    if (st_reg.cfg[HPM_TXACC_BIT])
    begin
      st_next.d_oe = 1'b1;
      st_next.d_out = 1'b1;
    end
    else if (!fifoen && !txen)
    begin
      st_next.d_oe = 1'b1;
      st_next.d_out = st_reg.s_rxd[1];
    end
    // Receive FIFO and FIFO select readout
    if (fifoen && digf && rclk_rise && st_reg.fcount != (FW+1)'(FIFO_DEPTH))
    begin
      st_next.fifo[st_reg.rptr + FW'(st_reg.fcount)] = st_reg.s_rxd[1];
      st_next.fcount = st_reg.fcount + (FW+1)'(1);
    end
    if (fsel && sck_rise && st_reg.fcount != '0)
    begin
      st_next.d_oe = 1'b1;
      st_next.d_out = st_reg.fifo[st_reg.rptr];
      st_next.rptr = st_reg.rptr + FW'(1);
      st_next.fcount = st_next.fcount - (FW+1)'(1);
    end
    else if (fsel)
    begin
      st_next.d_oe = st_reg.d_oe;
      st_next.d_out = st_reg.d_out;
    end
    if (!fifoen)
    begin
      st_next.fcount = '0;
      st_next.rptr = '0;
    end
    fifo_full = fifoen && st_reg.fcount >= limit && limit != '0;
    // Clock pin function decode
    st_next.p7_oe = 1'b1;
    if (!digf)
      st_next.p7 = st_reg.s_bb[1];
    else if (fifoen)
      st_next.p7 = fifo_full;
    else
      st_next.p7 = st_reg.s_rclk[1];
    // Reset pin
    st_next.rst_oe = st_reg.rdrive;
    st_next.rst_o = 1'b0;
    if (st_reg.rdrive)
    begin
      if (st_reg.rcnt == CW'(RST_DRIVE_CYC - 1))
        st_next.rdrive = 1'b0;
      else
        st_next.rcnt = st_reg.rcnt + CW'(1);
    end
    st_next.devrst = st_reg.rdrive | ~st_reg.s_rst[1];
    // External interrupt / valid data pin
    ext_low = ~vdmode & ~st_reg.s_ext[1];
    st_next.ext_prev = ext_low;
    st_next.p16_oe = vdmode;
    st_next.p16 = vdmode & st_reg.s_vd[1];
    st_next.wake = ext_low & st_reg.cfg[HPM_SLEEP_BIT];
    // Host clock divider
    if (st_reg.ccnt >= st_reg.cfg[HPM_CLKDIV_LSB +: HPM_CLKDIV_W])
    begin
      st_next.ccnt = '0;
      st_next.cout = ~st_reg.cout;
    end
    else
      st_next.ccnt = st_reg.ccnt + HPM_CLKDIV_W'(1);
    if (!st_reg.cfg[HPM_HOST_CLOCK_OUTPUT_EN_BIT])
      st_next.cout = 1'b0;
    // AXI4-Lite slave
    st_next.arready = 1'b0;
    st_next.awready = 1'b0;
    st_next.wready = 1'b0;
    case (st_reg.bus)
      HPM_IDLE:
      begin
        if (s_axi_awvalid && !st_reg.awok)
        begin
          st_next.awok = 1'b1;
          st_next.awready = 1'b1;
          st_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.wok)
        begin
          st_next.wok = 1'b1;
          st_next.wready = 1'b1;
          st_next.wdata = s_axi_wdata;
          st_next.wstrb = s_axi_wstrb;
        end
        if (st_reg.awok && st_reg.wok)
        begin
          st_next.awok = 1'b0;
          st_next.wok = 1'b0;
          st_next.bvalid = 1'b1;
          st_next.bresp = HPM_RESP_OK;
          st_next.bus = HPM_WRESP;
          case (st_reg.awaddr)
            HPM_CFG_OFF:
              for (int b = 0; b < 4; b++)
                if (st_reg.wstrb[b])
                  st_next.cfg[8*b +: 8] = st_reg.wdata[8*b +: 8];
            HPM_IEN_OFF:
              if (st_reg.wstrb[0])
                st_next.ien = st_reg.wdata[HPM_NEV-1:0];
            HPM_ICLR_OFF:
              if (st_reg.wstrb[0])
                clr = st_reg.wdata[HPM_NEV-1:0];
            HPM_STAT_OFF, HPM_FIFO_OFF:
              ;
            default:
              st_next.bresp = HPM_RESP_SLVERR;
          endcase
        end
        else if (s_axi_arvalid && !st_reg.awok && !st_reg.wok)
        begin
          st_next.arready = 1'b1;
          st_next.rvalid = 1'b1;
          st_next.rresp = HPM_RESP_OK;
          st_next.bus = HPM_RRESP;
          case (s_axi_araddr)
            HPM_CFG_OFF: rd = st_reg.cfg;
            HPM_STAT_OFF: rd = 32'(st_reg.stat);
            HPM_IEN_OFF: rd = 32'(st_reg.ien);
            HPM_ICLR_OFF: rd = 32'h0000_0000;
            HPM_FIFO_OFF: rd = 32'(st_reg.fcount);
            default: st_next.rresp = HPM_RESP_SLVERR;
          endcase
          st_next.rdata = rd;
        end
      end
      HPM_WRESP:
        if (s_axi_bready)
        begin
          st_next.bvalid = 1'b0;
          st_next.bus = HPM_IDLE;
        end
      HPM_RRESP:
        if (s_axi_rready)
        begin
          st_next.rvalid = 1'b0;
          st_next.bus = HPM_IDLE;
        end
      default:
        st_next.bus = HPM_IDLE;
    endcase
    // Sticky events, set wins over clear
    ev = core_events;
    ev[HPM_EV_FFILL] = core_events[HPM_EV_FFILL] | fifo_full;
    ev[HPM_EV_POR] = core_events[HPM_EV_POR] | (st_reg.rdrive & st_reg.rcnt == '0);
    ev[HPM_EV_EXT] = ext_low & ~st_reg.ext_prev;
    ev[HPM_EV_DVALID] = core_events[HPM_EV_DVALID] | (vdmode & st_reg.s_vd[1]);
    st_next.stat = (st_reg.stat & ~clr) | ev;
    st_next.irq_n = ~|(st_next.stat & st_next.ien);
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg <= '0;
      st_reg.bus <= HPM_IDLE;
      st_reg.cfg <= HPM_CFG_RST;
      st_reg.rdrive <= 1'b1;
      st_reg.d_out <= 1'b1;
      st_reg.txd <= 1'b1;
      st_reg.irq_n <= 1'b1;
      st_reg.s_cs <= 2'h3;
      st_reg.s_dat <= 2'h3;
      st_reg.s_rst <= 2'h3;
      st_reg.s_ext <= 2'h3;
    end
    else
      st_reg <= st_next;
  end

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign data_fifo_select_pin_out = st_reg.d_out;
  assign data_fifo_select_pin_oe = st_reg.d_oe;
  assign tx_mod_data = st_reg.txd;
  assign recclk_fifoint_filtcap_pin_out = st_reg.p7;
  assign recclk_fifoint_filtcap_pin_oe = st_reg.p7_oe;
  assign reset_bidir_pin_out = st_reg.rst_o;
  assign reset_bidir_pin_oe = st_reg.rst_oe;
  assign device_reset = st_reg.devrst;
  assign ext_irq_valid_data_pin_out = st_reg.p16;
  assign ext_irq_valid_data_pin_oe = st_reg.p16_oe;
  assign wake_event = st_reg.wake;
  assign interrupt_request_output_n = st_reg.irq_n;
  assign host_clock_output = st_reg.cout;
endmodule // hpm_pin_mux
`default_nettype wire

// *** hpm_chk.sv ***
// Port checker for the host pin function mux
`timescale 1ns/1ps
`default_nettype none
module hpm_chk
  import hpm_pkg::*;
#(
  parameter int RST_DRIVE_CYC = HPM_RST_DRIVE_CYC
)(
  input wire logic clock,
  input wire logic rstn,
  input wire logic s_axi_awready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic sync_valid,
  input wire logic recclk_fifoint_filtcap_pin_oe,
  input wire logic reset_bidir_pin_in,
  input wire logic reset_bidir_pin_out,
  input wire logic reset_bidir_pin_oe,
  input wire logic device_reset,
  input wire logic ext_irq_valid_data_pin_in,
  input wire logic ext_irq_valid_data_pin_out,
  input wire logic ext_irq_valid_data_pin_oe,
  input wire logic wake_event,
  input wire logic interrupt_request_output_n
);
  logic [31:0] run_reg;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // Cycles the reset pin has been driven
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      run_reg <= 32'h0;
    else
      run_reg <= reset_bidir_pin_oe ? run_reg + 32'h1 : 32'h0;
  end
  rst_drive_len_a: assert property ($fell(reset_bidir_pin_oe) |-> run_reg == RST_DRIVE_CYC)
    else $error("reset pin drive length wrong");
  rst_drive_low_a: assert property (reset_bidir_pin_oe |-> !reset_bidir_pin_out)
    else $error("reset pin driven high");
  rst_input_a: assert property ((!reset_bidir_pin_oe && !reset_bidir_pin_in) [*4] |=> device_reset)
    else $error("reset input ignored");
  clk_pin_oe_a: assert property ($past(rstn, 2) |-> recclk_fifoint_filtcap_pin_oe)
    else $error("clock pin not driven");
  valid_out_a: assert property (($stable(sync_valid) && ext_irq_valid_data_pin_oe) [*5]
    |-> ext_irq_valid_data_pin_out == sync_valid)
    else $error("valid data pin wrong");
  wake_src_a: assert property ($rose(wake_event) |-> !$past(ext_irq_valid_data_pin_in, 3))
    else $error("wake without low input");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than a cycle");
  cover property ($fell(reset_bidir_pin_oe));
  cover property ($fell(interrupt_request_output_n));
  cover property (wake_event);
endmodule // hpm_chk
bind hpm_pin_mux hpm_chk #(.RST_DRIVE_CYC(RST_DRIVE_CYC)) hpm_chk_inst (.clock, .rstn, .s_axi_awready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .sync_valid, .recclk_fifoint_filtcap_pin_oe, .reset_bidir_pin_in,
  .reset_bidir_pin_out, .reset_bidir_pin_oe, .device_reset, .ext_irq_valid_data_pin_in,
  .ext_irq_valid_data_pin_out, .ext_irq_valid_data_pin_oe, .wake_event, .interrupt_request_output_n);
`default_nettype wire

// *** hpm_host.sv ***
// Host controller model on the data and serial pins
`timescale 1ns/1ps
`default_nettype none
module hpm_host (
  input wire logic go,
  input wire logic fifo_use,
  input wire logic tx_en,
  input wire logic dval,
  input wire logic pin_oe,
  input wire logic pin_out,
  output logic pin_in,
  output logic sclk,
  output logic cs_n
);
  // Host lets go with transmit register on, low for FIFO
  assign pin_in = tx_en ? (pin_oe ? pin_out : 1'b1) : (fifo_use ? 1'b0 : dval);
  // Frame of 16 link clocks, clock still between frames
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    forever
    begin
      @(posedge go);
      cs_n <= 1'b0;
      repeat (16)
      begin
        #40 sclk <= 1'b1;
        #40 sclk <= 1'b0;
      end
      #40 cs_n <= 1'b1;
    end
  end
endmodule // hpm_host
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the host pin function mux
`timescale 1ns/1ps
`default_nettype none
module testbench
  import hpm_pkg::*;
;
  localparam int RDC = 20;
  logic clock, rstn, awv, awr, wv, wrdy, bv, brd, arv, arr, rv, rrd, rxd, rxc, rxb, sv, go, fu, txe, dv;
  logic hrst, hext, sck, csn, dpi, dpo, dpoe, txm, cpo, cpoe, rpi, rpo, rpoe, drst, epi, epo, epoe, wk, irqn, hclk;
  logic [7:0] awa, ara, ev;
  logic [31:0] wd, rdat, d;
  logic [1:0] br, rr, rsp;
  int n_mismatch, checks_done, i;
  hpm_pin_mux #(.RST_DRIVE_CYC(RDC)) hpm_pin_mux_inst (.clock(clock), .rstn(rstn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rrd), .rx_data(rxd), .rx_recclk(rxc), .rx_baseband(rxb), .sync_valid(sv), .core_events(ev),
    .serial_clock(sck), .serial_chip_select_n(csn), .data_fifo_select_pin_in(dpi), .data_fifo_select_pin_out(dpo),
    .data_fifo_select_pin_oe(dpoe), .tx_mod_data(txm), .recclk_fifoint_filtcap_pin_out(cpo),
    .recclk_fifoint_filtcap_pin_oe(cpoe), .reset_bidir_pin_in(rpi), .reset_bidir_pin_out(rpo),
    .reset_bidir_pin_oe(rpoe), .device_reset(drst), .ext_irq_valid_data_pin_in(epi),
    .ext_irq_valid_data_pin_out(epo), .ext_irq_valid_data_pin_oe(epoe), .wake_event(wk),
    .interrupt_request_output_n(irqn), .host_clock_output(hclk));
  hpm_host hpm_host_inst (.go(go), .fifo_use(fu), .tx_en(txe), .dval(dv), .pin_oe(dpoe), .pin_out(dpo),
    .pin_in(dpi), .sclk(sck), .cs_n(csn));
  // Pull-ups on reset and interrupt pins
  assign rpi = rpoe ? rpo : hrst;
  assign epi = epoe ? epo : hext;
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic w8;
    repeat (8) @(posedge clock);
  endtask
  task automatic tend(input string s);
    $display("Test %s finished", s);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, da, dw, tb;
    logic [1:0] r;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    {da, dw, tb} = 3'h0;
    r = 2'h0;
    while (!tb)
    begin
      @(negedge clock);
      {ta, tw, tb, r} = {awr, wrdy, bv && brd, br};
      @(posedge clock);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      {da, dw} = {da | ta, dw | tw};
      brd <= da && dw && !tb;
    end
    chk("bresp", HPM_RESP_OK, r);
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    logic tr, tv, sa;
    ara <= a;
    arv <= 1'b1;
    {tv, sa} = 2'h0;
    while (!tv)
    begin
      @(negedge clock);
      {tr, tv, v, r} = {arr, rv && rrd, rdat, rr};
      sa = sa | tr;
      @(posedge clock);
      if (tr) arv <= 1'b0;
      rrd <= (rrd || tr) && !tv;
    end
    chk("arready", 1, sa);
    @(posedge clock);
  endtask
  task automatic close_out;
    $display("Counts %0d mismatches %0d checks", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial
  begin
    {rstn, awv, wv, brd, arv, rrd, rxd, rxc, rxb, sv, go, fu, txe} = 13'h0;
    {dv, hrst, hext, awa, ara, ev, wd} = '1;
    ev = 8'h00;
    n_mismatch = 0;
    checks_done = 0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    chk("rst oe", 1, rpoe);
    chk("rst out", 0, rpo);
    repeat (RDC + 8) @(posedge clock);
    chk("rst free", 0, rpoe);
    hrst <= 1'b0;
    w8;
    chk("dev rst", 1, drst);
    hrst <= 1'b1;
    w8;
    chk("dev run", 0, drst);
    rd(HPM_CFG_OFF, d, rsp);
    chk("cfg", HPM_CFG_RST, d);
    rd(8'h20, d, rsp);
    chk("unmapped", HPM_RESP_SLVERR, rsp);
    tend("reset and registers");
    for (i = 0; i < 4; i++)
    begin
      wr(HPM_CFG_OFF, i[1] ? 32'h10 : 32'h0);
      {rxb, rxc, rxd} <= {3{i[0]}};
      w8;
      chk("clk pin", i[0], cpo);
      chk("clk oe", 1, cpoe);
      chk("rx data", i[0], dpo);
    end
    {rxb, rxc, rxd} <= 3'h0;
    fu <= 1'b1;
    wr(HPM_CFG_OFF, 32'h0000_2050);
    w8;
    for (i = 0; i < 2; i++)
    begin
      chk("fifo int", 0, cpo);
      rxd <= (i == 0);
      rxc <= 1'b1;
      w8;
      rxc <= 1'b0;
      w8;
    end
    chk("fifo int", 1, cpo);
    go <= 1'b1;
    repeat (14) @(posedge clock);
    chk("first bit", 1, dpo);
    chk("first oe", 1, dpoe);
    go <= 1'b0;
    repeat (16) @(posedge clock);
    chk("next bit", 0, dpo);
    repeat (250) @(posedge clock);
    tend("pin functions");
    fu <= 1'b0;
    for (i = 0; i < 3; i++)
    begin
      wr(HPM_CFG_OFF, (i == 2) ? 32'h1 : 32'h0);
      txe <= (i == 2);
      dv <= i[0];
      w8;
      chk("tx data", i > 0, txm);
    end
    wr(HPM_CFG_OFF, 32'h801);
    w8;
    chk("tx access", 1, dpoe);
    tend("tx data");
    wr(HPM_IEN_OFF, 32'h0);
    wr(HPM_ICLR_OFF, 32'hFF);
    ev <= 8'h01;
    @(posedge clock);
    ev <= 8'h00;
    w8;
    chk("irq masked", 1, irqn);
    rd(HPM_STAT_OFF, d, rsp);
    chk("stat src", 1, d[HPM_EV_TXRDY]);
    wr(HPM_IEN_OFF, 32'h21);
    w8;
    chk("irq on", 0, irqn);
    wr(HPM_ICLR_OFF, 32'h01);
    w8;
    chk("irq clr", 1, irqn);
    hext <= 1'b0;
    w8;
    chk("irq ext", 0, irqn);
    rd(HPM_STAT_OFF, d, rsp);
    chk("stat ext", 1, d[HPM_EV_EXT]);
    wr(HPM_CFG_OFF, 32'h400);
    w8;
    chk("wake", 1, wk);
    hext <= 1'b1;
    wr(HPM_ICLR_OFF, 32'hFF);
    tend("interrupts");
    wr(HPM_CFG_OFF, 32'h100);
    for (i = 0; i < 2; i++)
    begin
      sv <= (i == 0);
      w8;
      chk("valid", i == 0, epo);
      chk("valid oe", 1, epoe);
    end
    wr(HPM_CFG_OFF, 32'h0001_0200);
    w8;
    @(negedge clock);
    d[0] = hclk;
    repeat (2) @(negedge clock);
    chk("host clk", 1, hclk ^ d[0]);
    tend("valid data and clock out");
    close_out;
  end
  initial
  begin
    #100000;
    n_mismatch++;
    close_out;
  end
endmodule // testbench
`default_nettype wire
